// [design/wcl_cache.v]
// Four-way write-back cache with line state, pseudo-LRU and copy-back.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`include "wcl_regs.vh"
`default_nettype none

module wcl_cache #(
  parameter IDX_W = 4                        // Set index width
) (
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Core request side
  input  wire        core_req_valid,
  output wire        core_req_ready,
  input  wire        core_req_write,
  input  wire [31:0] core_req_addr,
  input  wire [31:0] core_req_wdata,
  input  wire        core_req_cacheable,
  input  wire        page_write_through,
  output reg         core_rsp_valid,
  output reg  [31:0] core_rsp_rdata,
  // External bus, one word per acknowledge
  output wire        bus_valid,
  output wire        bus_write,
  output wire [31:0] bus_addr,
  output wire [31:0] bus_wdata,
  input  wire        bus_ack,
  input  wire [31:0] bus_rdata,
  input  wire        line_policy_select,
  // Snoop from other masters
  input  wire        snoop_valid,
  output wire        snoop_ready,
  input  wire [31:0] snoop_addr,
  input  wire        snoop_inv,
  output reg         snoop_hit_modified,
  output reg         bus_backoff
);

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam SETS  = 1 << IDX_W;
  localparam LINES = SETS * 4;
  localparam TAG_W = 28 - IDX_W;             // Above index and offset
  localparam LN_W  = IDX_W + 2;              // Set plus way

  // One-hot controller states
  localparam [4:0] S_IDLE = 5'h01;           // Lookup and snoop
  localparam [4:0] S_WT   = 5'h02;           // Single bus write
  localparam [4:0] S_FILL = 5'h04;           // Line fill or one read
  localparam [4:0] S_CB   = 5'h08;           // Copy-back drain
  localparam [4:0] S_SNP  = 5'h10;           // Snoop write-back

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg [31:0]      data_mem [0:LINES*4-1];    // Four words per line
  reg [TAG_W-1:0] tag_mem  [0:LINES-1];      // One tag per line
  reg [2*LINES-1:0] st_reg;                  // Two state bits a line
  reg [3*SETS-1:0]  plru_reg;                // Three tree bits a set
  reg [31:0]      cb_buf [0:3];              // Copy-back buffer
  reg [27:0]      cb_line_reg;               // Copy-back line address
  reg             cb_pend_reg;               // Copy-back waiting

  reg [4:0]       fsm_reg;
  reg [1:0]       cnt_reg;                   // Word counter on bus
  reg             rq_write_reg;
  reg [31:0]      rq_addr_reg;
  reg [31:0]      rq_wdata_reg;
  reg             rq_pwt_reg;
  reg             alloc_reg;                 // Fill installs a line
  reg [LN_W-1:0]  line_reg;                  // Victim or snooped line
  reg             fill_pol_reg;              // Policy at first word
  reg             snp_inv_reg;

  // Policy pin synchroniser and strap
  reg             pol_s1_reg;
  reg             pol_s2_reg;
  reg             pol_s3_reg;
  reg             pol_reg;                   // Filtered policy level
  reg [1:0]       strap_cnt_reg;
  reg             strap_done_reg;
  reg             wb_mode_reg;               // Write-back mode strap

  // Software registers
  reg             ctrl_en_reg;               // Cacheability enable
  reg [31:0]      hit_cnt_reg;
  reg [31:0]      miss_cnt_reg;

  // ****************************************************************
  // Lookup for core and snoop addresses
  // ****************************************************************
  wire [IDX_W-1:0] c_set = core_req_addr[IDX_W+3:4];
  wire [TAG_W-1:0] c_tag = core_req_addr[31:IDX_W+4];
  wire [IDX_W-1:0] n_set = snoop_addr[IDX_W+3:4];
  wire [TAG_W-1:0] n_tag = snoop_addr[31:IDX_W+4];

  reg        c_hit;
  reg [1:0]  c_way;
  reg [1:0]  c_st;
  reg        n_hit;
  reg [1:0]  n_way;
  reg [1:0]  n_st;
  reg        inv_any;
  reg [1:0]  inv_way;
  reg [1:0]  vic_way;
  reg [2:0]  c_tree;
  integer    w;

  // Tag compare; invalid lines never match
  always @* begin
    c_hit   = 1'b0;
    c_way   = 2'h0;
    c_st    = `WCL_ST_INV;
    n_hit   = 1'b0;
    n_way   = 2'h0;
    n_st    = `WCL_ST_INV;
    inv_any = 1'b0;
    inv_way = 2'h0;
    for (w = 3; w >= 0; w = w - 1) begin
      if (st_reg[2*{c_set, w[1:0]} +: 2] != `WCL_ST_INV &&
          tag_mem[{c_set, w[1:0]}] == c_tag) begin
        c_hit = 1'b1;
        c_way = w[1:0];
        c_st  = st_reg[2*{c_set, w[1:0]} +: 2];
      end
      if (st_reg[2*{n_set, w[1:0]} +: 2] != `WCL_ST_INV &&
          tag_mem[{n_set, w[1:0]}] == n_tag) begin
        n_hit = 1'b1;
        n_way = w[1:0];
        n_st  = st_reg[2*{n_set, w[1:0]} +: 2];
      end
      // Lowest invalid way wins the placement
      if (st_reg[2*{c_set, w[1:0]} +: 2] == `WCL_ST_INV) begin
        inv_any = 1'b1;
        inv_way = w[1:0];
      end
    end
    c_tree = plru_reg[3*c_set +: 3];
    // Invalid way first, tree choice otherwise
    if (inv_any)
      vic_way = inv_way;
    else if (!c_tree[0])
      vic_way = {1'b0, c_tree[1]};
    else
      vic_way = {1'b1, c_tree[2]};
  end

  // Tree update pointing away from the way just used
  function [2:0] plru_touch;
    input [2:0] tree;
    input [1:0] way;
    begin
      plru_touch = tree;
      plru_touch[0] = ~way[1];
      if (way[1])
        plru_touch[2] = ~way[0];
      else
        plru_touch[1] = ~way[0];
    end
  endfunction

  wire [LN_W-1:0] vic_line = {c_set, vic_way};
  wire [1:0]      vic_st   = st_reg[2*vic_line +: 2];
  wire            cache_ok = core_req_cacheable & ctrl_en_reg;
  wire            is_idle  = fsm_reg == S_IDLE;
  wire [LN_W-1:0] rq_line  = {rq_addr_reg[IDX_W+3:4], line_reg[1:0]};

  // Snoops take the controller ahead of the core
  assign snoop_ready    = is_idle & strap_done_reg;
  assign core_req_ready = is_idle & strap_done_reg & ~snoop_valid;

  // ****************************************************************
  // Bus drive, muxed from held registers
  // ****************************************************************
  assign bus_valid = ~is_idle;
  assign bus_write = (fsm_reg != S_FILL);
  assign bus_addr  = (fsm_reg == S_CB) ? {cb_line_reg, cnt_reg, 2'h0} :
                     (fsm_reg == S_SNP) ?
                       {tag_mem[line_reg], line_reg[LN_W-1:2],
                        cnt_reg, 2'h0} :
                     (fsm_reg == S_FILL && alloc_reg) ?
                       {rq_addr_reg[31:4], cnt_reg, 2'h0} :
                     rq_addr_reg;
  assign bus_wdata = (fsm_reg == S_CB) ? cb_buf[cnt_reg] :
                     (fsm_reg == S_SNP) ? data_mem[{line_reg, cnt_reg}] :
                     rq_wdata_reg;

  // ****************************************************************
  // Main controller
  // ****************************************************************
  integer k;
  always @(posedge aclk) begin
    if (!aresetn) begin
      fsm_reg            <= S_IDLE;
      st_reg             <= {2*LINES{1'b0}}; // All lines invalid
      plru_reg           <= {3*SETS{1'b0}};
      cb_pend_reg        <= 1'b0;
      cb_line_reg        <= 28'h0;
      cnt_reg            <= 2'h0;
      rq_write_reg       <= 1'b0;
      rq_addr_reg        <= 32'h0;
      rq_wdata_reg       <= 32'h0;
      rq_pwt_reg         <= 1'b0;
      alloc_reg          <= 1'b0;
      line_reg           <= {LN_W{1'b0}};
      fill_pol_reg       <= 1'b0;
      snp_inv_reg        <= 1'b0;
      core_rsp_valid     <= 1'b0;
      core_rsp_rdata     <= 32'h0;
      snoop_hit_modified <= 1'b0;
      bus_backoff        <= 1'b0;
      hit_cnt_reg        <= 32'h0;
      miss_cnt_reg       <= 32'h0;
    end else begin
      core_rsp_valid     <= 1'b0;
      snoop_hit_modified <= 1'b0;
      case (fsm_reg)
        S_IDLE: begin
          cnt_reg <= 2'h0;
          if (snoop_valid && snoop_ready) begin
            line_reg    <= {n_set, n_way};
            snp_inv_reg <= snoop_inv;
            if (n_hit && n_st == `WCL_ST_MOD) begin
              // Hold the other master off until memory is current
              snoop_hit_modified <= 1'b1;
              bus_backoff        <= 1'b1;
              fsm_reg            <= S_SNP;
            end else if (n_hit && snoop_inv) begin
              st_reg[2*{n_set, n_way} +: 2] <= `WCL_ST_INV;
            end
          end else if (core_req_valid && core_req_ready) begin
            rq_write_reg <= core_req_write;
            rq_addr_reg  <= core_req_addr;
            rq_wdata_reg <= core_req_wdata;
            rq_pwt_reg   <= page_write_through;
            line_reg     <= {c_set, c_hit ? c_way : vic_way};
            if (c_hit) begin
              hit_cnt_reg <= hit_cnt_reg + 32'h1;
              plru_reg[3*c_set +: 3] <= plru_touch(c_tree, c_way);
            end else begin
              miss_cnt_reg <= miss_cnt_reg + 32'h1;
            end
            if (!core_req_write && c_hit) begin
              // Read hit served from the array
              core_rsp_valid <= 1'b1;
              core_rsp_rdata <=
                data_mem[{c_set, c_way, core_req_addr[3:2]}];
            end else if (!core_req_write) begin
              // Read miss: line fill only when cacheable
              alloc_reg <= cache_ok;
              fsm_reg   <= S_FILL;
              if (cache_ok && vic_st == `WCL_ST_MOD) begin
                // Park modified victim before overwriting it
                cb_pend_reg <= 1'b1;
                cb_line_reg <= {tag_mem[vic_line], c_set};
                for (k = 0; k < 4; k = k + 1)
                  cb_buf[k] <= data_mem[{vic_line, k[1:0]}];
              end
            end else if (c_hit) begin
              data_mem[{c_set, c_way, core_req_addr[3:2]}] <=
                core_req_wdata;
              if (c_st == `WCL_ST_SHR) begin
                // Shared doubles as write-through
                fsm_reg <= S_WT;
              end else begin
                // Cache only; exclusive turns modified
                core_rsp_valid <= 1'b1;
                st_reg[2*{c_set, c_way} +: 2] <= `WCL_ST_MOD;
              end
            end else begin
              // Write miss: no allocation, states kept
              fsm_reg <= S_WT;
            end
          end
        end
        S_WT: begin
          if (bus_ack) begin
            core_rsp_valid <= 1'b1;
            fsm_reg        <= S_IDLE;
          end
        end
        S_FILL: begin
          if (bus_ack) begin
            cnt_reg <= cnt_reg + 2'h1;
            if (alloc_reg)
              data_mem[{rq_line, cnt_reg}] <= bus_rdata;
            if (cnt_reg == 2'h0)
              fill_pol_reg <= pol_reg;
            if (!alloc_reg || cnt_reg == rq_addr_reg[3:2])
              core_rsp_rdata <= bus_rdata;
            if (!alloc_reg) begin
              core_rsp_valid <= 1'b1;
              fsm_reg        <= S_IDLE;
            end else if (cnt_reg == 2'h3) begin
              core_rsp_valid <= 1'b1;
              tag_mem[rq_line] <= rq_addr_reg[31:IDX_W+4];
              // Exclusive only for write-back fills, shared else
              if (!rq_pwt_reg && wb_mode_reg &&
                  ((cnt_reg == 2'h0) ? pol_reg : fill_pol_reg))
                st_reg[2*rq_line +: 2] <= `WCL_ST_EXC;
              else
                st_reg[2*rq_line +: 2] <= `WCL_ST_SHR;
              plru_reg[3*rq_line[LN_W-1:2] +: 3] <=
                plru_touch(plru_reg[3*rq_line[LN_W-1:2] +: 3],
                           rq_line[1:0]);
              fsm_reg <= cb_pend_reg ? S_CB : S_IDLE;
            end
          end
        end
        S_CB: begin
          // Drain parked victim after the new line is
          if (bus_ack) begin
            cnt_reg <= cnt_reg + 2'h1;
            if (cnt_reg == 2'h3) begin
              cb_pend_reg <= 1'b0;
              fsm_reg     <= S_IDLE;
            end
          end
        end
        S_SNP: begin
          // Snooped modified line written back word by word
          if (bus_ack) begin
            cnt_reg <= cnt_reg + 2'h1;
            if (cnt_reg == 2'h3) begin
              bus_backoff <= 1'b0;
              st_reg[2*line_reg +: 2] <=
                snp_inv_reg ? `WCL_ST_INV : `WCL_ST_SHR;
              fsm_reg <= S_IDLE;
            end
          end
        end
        default: fsm_reg <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Policy pin: three-stage sync, strap captured after release
  // ****************************************************************
  // Stages run through reset, so a steady strap is settled by capture
  always @(posedge aclk) begin
    pol_s1_reg <= line_policy_select;
    pol_s2_reg <= pol_s1_reg;
    pol_s3_reg <= pol_s2_reg;
    if (!aresetn) begin
      pol_reg        <= 1'b0;
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'b0;
      wb_mode_reg    <= 1'b0;
    end else begin
      // Change accepted once the later two stages agree
      if (pol_s2_reg == pol_s3_reg)
        pol_reg <= pol_s3_reg;
      if (!strap_done_reg) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
        if (strap_cnt_reg == `WCL_STRAP_SETTLE) begin
          // Low strap forces every fill to write-through
          wb_mode_reg    <= pol_reg;
          strap_done_reg <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  reg        aw_held_reg;
  reg [3:0]  aw_addr_reg;
  reg        w_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;

  // Address and data taken in either order, one write at a time
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire [31:0] status_word = {29'h0, cb_pend_reg, ~is_idle, wb_mode_reg};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= 4'h0;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h0;
      ctrl_en_reg  <= `WCL_CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_held_reg && w_held_reg) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Read-only words accept and ignore; unmapped gives SLVERR
        s_axi_bresp  <= (aw_addr_reg[1:0] == 2'h0) ? 2'h0 : 2'h2;
        if (aw_addr_reg == `WCL_CTRL_OFFSET && w_strb_reg[0])
          ctrl_en_reg <= w_data_reg[`WCL_CTRL_EN_BIT];
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `WCL_CTRL_OFFSET:     s_axi_rdata <= {31'h0, ctrl_en_reg};
          `WCL_STATUS_OFFSET:   s_axi_rdata <= status_word;
          `WCL_HIT_CNT_OFFSET:  s_axi_rdata <= hit_cnt_reg;
          `WCL_MISS_CNT_OFFSET: s_axi_rdata <= miss_cnt_reg;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // wcl_cache

`default_nettype wire

// [design/wcl_regs.vh]
// Constants for the write-back cache line state block.
`ifndef WCL_REGS_VH
`define WCL_REGS_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define WCL_CTRL_OFFSET      4'h0
`define WCL_STATUS_OFFSET    4'h4
`define WCL_HIT_CNT_OFFSET   4'h8
`define WCL_MISS_CNT_OFFSET  4'hc

// Control fields and reset
`define WCL_CTRL_EN_BIT      0
`define WCL_CTRL_RESET       1'h1

// Status fields
`define WCL_STAT_WB_BIT      0
`define WCL_STAT_BUSY_BIT    1
`define WCL_STAT_CBP_BIT     2

// ****************************************************************
// Line states, high bit then low bit
// ****************************************************************
`define WCL_ST_INV           2'h0
`define WCL_ST_EXC           2'h1
`define WCL_ST_MOD           2'h2
`define WCL_ST_SHR           2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define WCL_STRAP_SETTLE     2'h3

`endif

// [design/_unused_guard.v]
// Intentionally empty translation unit kept for path symmetry.
`default_nettype none
`default_nettype wire

// [tb/wcl_cache_checker.sv]
// Concurrent checks on the cache block's core, bus and snoop ports.
`default_nettype none
module wcl_cache_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        core_rsp_valid,
  input wire logic        bus_valid,
  input wire logic        bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_ack,
  input wire logic        snoop_valid,
  input wire logic        snoop_ready,
  input wire logic        snoop_hit_modified,
  input wire logic        bus_backoff
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Word counter during a snoop write-back
  // ****
  logic [2:0] wb_cnt; // Words acked while the other master is held off
  always_ff @(posedge aclk) begin
    if (!aresetn || !bus_backoff) begin
      wb_cnt <= 3'h0;
    end else if (bus_valid && bus_ack) begin
      wb_cnt <= wb_cnt + 3'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****
  // Assertions
  // ****
  rsp_pulse_a: assert property (core_rsp_valid |=> !core_rsp_valid)
    else $error("core response longer than one cycle");
  hitm_cause_a: assert property (snoop_hit_modified |->
    $past(snoop_valid && snoop_ready)) else $error("hit flag without snoop");
  backoff_start_a: assert property ($rose(bus_backoff) |->
    snoop_hit_modified) else $error("backoff without modified hit");
  hitm_backoff_a: assert property (snoop_hit_modified |-> bus_backoff)
    else $error("modified hit without backoff");
  bus_hold_a: assert property (bus_valid && !bus_ack |=> bus_valid &&
    $stable(bus_addr) && $stable(bus_write)) else $error("bus request moved");
  wdata_hold_a: assert property (bus_valid && bus_write && !bus_ack |=>
    $stable(bus_wdata)) else $error("bus write data moved");
  backoff_write_a: assert property (bus_backoff && bus_valid |->
    bus_write) else $error("read issued during write-back");
  backoff_len_a: assert property ($fell(bus_backoff) |->
    wb_cnt == 3'h4) else $error("write-back not four words");
endmodule // wcl_cache_checker
`default_nettype wire

// [tb/wcl_bus_model.sv]
// External memory on the cache's system bus, prompt or slow per address.
`default_nettype none
module wcl_bus_model (
  input  wire logic        aclk,
  input  wire logic        bus_valid,
  input  wire logic        bus_write,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  output var  logic        bus_ack,
  output var  logic [31:0] bus_rdata,
  output var  int          n_rd,
  output var  int          n_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [31:0]]; // Words written so far
  int          dly;                // Wait cycles before the next ack
  initial begin
    bus_ack = 1'b0;
    bus_rdata = 32'h0;
    n_rd = 0;
    n_wr = 0;
    dly = 0;
  end
  // Ack each word; words with bit 3 set wait three cycles
  always @(posedge aclk) begin
    bus_ack <= 1'b0;
    bus_rdata <= ~bus_rdata; // Inverted each cycle outside acks, so the last word never holds
    if (bus_valid && bus_ack) begin
      if (bus_write) begin
        mem[bus_addr] = bus_wdata; // Write-back lands in memory
        n_wr++;
      end else begin
        n_rd++;
      end
      dly <= 0;
    end else if (bus_valid && dly < (bus_addr[3] ? 3 : 0)) begin
      dly <= dly + 1;
    end else if (bus_valid) begin
      bus_ack <= 1'b1;
      bus_rdata <= mem.exists(bus_addr) ? mem[bus_addr]
                                        : bus_addr ^ 32'h5a5a0000;
    end
  end
endmodule // wcl_bus_model
`default_nettype wire

// [tb/test_writeback_cache_line_state.sv]
// Self-checking bench for the four-way write-back cache block.
`default_nettype none
module test_writeback_cache_line_state;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic cv = 0, cw = 0, cc = 0, pw = 0, sv = 0, si = 0, lp = 1;
  logic [3:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, ca = 0, cd = 0, sa = 0, seed = 32'h12a4875c;
  wire awr, wr, arr, bv, rv, crd, crv, bval, bwr, ack, srd, hitm, boff;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, crdata, badr, bwd, brd;
  int nrd, nwr, fail_count = 0, compares = 0, cyc = 0, r0, w0;
  logic [32:0] exq [$];                 // Care bit and expected value
  logic [31:0] shadow [logic [31:0]];   // Latest data of each word
  always #2 aclk = ~aclk;
  wcl_cache u_wcl_cache (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .core_req_valid(cv),
    .core_req_ready(crd), .core_req_write(cw), .core_req_addr(ca),
    .core_req_wdata(cd), .core_req_cacheable(cc),
    .page_write_through(pw), .core_rsp_valid(crv),
    .core_rsp_rdata(crdata), .bus_valid(bval), .bus_write(bwr),
    .bus_addr(badr), .bus_wdata(bwd), .bus_ack(ack), .bus_rdata(brd),
    .line_policy_select(lp), .snoop_valid(sv), .snoop_ready(srd),
    .snoop_addr(sa), .snoop_inv(si), .snoop_hit_modified(hitm),
    .bus_backoff(boff)); // Policy pin strapped high from reset
  wcl_bus_model u_wcl_bus_model (.aclk(aclk), .bus_valid(bval),
    .bus_write(bwr), .bus_addr(badr), .bus_wdata(bwd), .bus_ack(ack),
    .bus_rdata(brd), .n_rd(nrd), .n_wr(nwr));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] v);
    logic [32:0] e;
    e = (exq.size() > 0) ? exq.pop_front() : 33'h0;
    compares++;
    if (e[32] && v !== e[31:0]) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e[31:0], v);
    end
  endtask
  task automatic cnt(input int er, input int ew);
    compares++;
    if (nrd - r0 !== er || nwr - w0 !== ew) begin
      fail_count++;
      $display("[FAIL] bus rd/wr exp %0d/%0d got %0d/%0d", er, ew,
               nrd - r0, nwr - w0);
    end
  endtask
  task automatic mchk(input logic [31:0] a);
    compares++;
    if (u_wcl_bus_model.mem[a] !== shadow[a]) begin
      fail_count++;
      $display("[FAIL] mem %h exp %h got %h", a, shadow[a],
               u_wcl_bus_model.mem[a]);
    end
  endtask
  // Core access, then bus traffic compared once the block is idle
  task automatic core_op(input logic w, input logic [31:0] a,
                         input logic c, input logic p, input int er,
                         input int ew);
    logic [31:0] d;
    d = xs();
    r0 = nrd;
    w0 = nwr;
    if (w) shadow[a] = d;
    exq.push_back({!w, shadow.exists(a) ? shadow[a] : a ^ 32'h5a5a0000});
    @(posedge aclk);
    {cv, cw, ca, cd, cc, pw} <= {1'b1, w, a, d, c, p};
    do @(posedge aclk); while (!crd);
    cv <= 1'b0;
    do @(posedge aclk); while (!crd);
    cnt(er, ew);
  endtask
  task automatic snoop(input logic [31:0] a, input logic inv, input int ew);
    r0 = nrd;
    w0 = nwr;
    @(posedge aclk);
    {sv, sa, si} <= {1'b1, a, inv};
    do @(posedge aclk); while (!srd);
    sv <= 1'b0;
    @(posedge aclk);
    do @(posedge aclk); while (!srd);
    cnt(0, ew);
  endtask
  // AXI4-Lite write, both channels offered together
  task automatic axi_wr(input logic [3:0] a, input logic [1:0] er);
    exq.push_back({1'b1, 30'h0, er});
    @(posedge aclk);
    {awa, wd, awv, wv, br} <= {a, xs(), 3'h7};
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while ((awv && !awr) || (wv && !wr));
    while (!bv) @(posedge aclk);
    br <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    exq.push_back({1'b1, ed});
    exq.push_back({1'b1, 30'h0, er});
    @(posedge aclk);
    {ara, arv, rr} <= {a, 2'h3};
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    while (!rv) @(posedge aclk);
    rr <= 1'b0;
  endtask
  // ****
  // Result monitor and timeout
  // ****
  always @(posedge aclk) begin
    if (crv) chk("core_rsp_rdata", crdata);
    if (rv && rr) chk("rdata", rdata);
    if (rv && rr) chk("rresp", {30'h0, rresp});
    if (bv && br) chk("bresp", {30'h0, bresp});
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    axi_wr(4'h0, 2'h0);
    axi_rd(4'h0, 32'h1, 2'h0);
    axi_rd(4'h2, 32'h0, 2'h2);
    core_op(0, 32'h1010, 1, 0, 4, 0);  // Read miss fills exclusive
    core_op(0, 32'h1014, 1, 0, 0, 0);  // Tag hit, no bus
    core_op(1, 32'h1018, 1, 0, 0, 0);  // Exclusive to modified
    snoop(32'h1010, 0, 4);             // Modified snooped out
    mchk(32'h1018);                    // Memory current after it
    core_op(1, 32'h1010, 1, 0, 0, 1);  // Shared write goes out
    core_op(0, 32'h1018, 1, 0, 0, 0);  // Still cached after snoop
    core_op(1, 32'h2010, 1, 0, 0, 1);  // Write miss to bus
    core_op(0, 32'h2010, 1, 0, 4, 0);  // Not allocated by write
    core_op(0, 32'h6010, 0, 0, 1, 0);  // Uncacheable read
    core_op(0, 32'h6010, 0, 0, 1, 0);  // Still not filled
    core_op(0, 32'h3010, 1, 1, 4, 0);  // Fill with pwt set
    core_op(1, 32'h3010, 1, 0, 0, 1);  // Shared marks write-through
    for (int k = 0; k < 4; k++) begin
      core_op(0, 32'h20 + k * 32'h100, 1, 0, 4, 0); // Free ways
      core_op(1, 32'h20 + k * 32'h100, 1, 0, 0, 0); // No bus
    end
    core_op(0, 32'h420, 1, 0, 4, 4);   // Victim copied back
    mchk(32'h20);                      // Copy-back data
    snoop(32'h420, 1, 0);              // Clean line invalidated
    core_op(0, 32'h420, 1, 0, 4, 0);   // Refetch after invalidate
    {lp, aresetn} <= 2'h0;             // Low strap over a second reset
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    core_op(0, 32'h1010, 1, 0, 4, 0);  // Fill under low strap
    core_op(1, 32'h1010, 1, 0, 0, 1);  // Shared, write goes out
    repeat (4) @(posedge aclk);
    results();
  end
endmodule // test_writeback_cache_line_state
bind wcl_cache wcl_cache_checker u_wcl_cache_checker (.aclk(aclk),
  .aresetn(aresetn), .core_rsp_valid(core_rsp_valid),
  .bus_valid(bus_valid), .bus_write(bus_write), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_ack(bus_ack), .snoop_valid(snoop_valid),
  .snoop_ready(snoop_ready), .snoop_hit_modified(snoop_hit_modified),
  .bus_backoff(bus_backoff));
`default_nettype wire
